//--- rgbog_pkg.sv
package rgbog_pkg;
  // printed offsets are register indices; byte address is four times
  localparam logic [5:0] RGBOG_IDX_RED_OFS = 6'h20;
  localparam logic [5:0] RGBOG_IDX_GRN_OFS = 6'h21;
  localparam logic [5:0] RGBOG_IDX_BLU_OFS = 6'h22;
  localparam logic [5:0] RGBOG_IDX_ALL_OFS = 6'h23;
  localparam logic [5:0] RGBOG_IDX_RED_GLO = 6'h24;
  localparam logic [5:0] RGBOG_IDX_GRN_GLO = 6'h25;
  localparam logic [5:0] RGBOG_IDX_BLU_GLO = 6'h26;
  localparam logic [5:0] RGBOG_IDX_ALL_GLO = 6'h27;
  localparam logic [5:0] RGBOG_IDX_RED_GHI = 6'h28;
  localparam logic [5:0] RGBOG_IDX_GRN_GHI = 6'h29;
  localparam logic [5:0] RGBOG_IDX_BLU_GHI = 6'h2A;
  localparam logic [5:0] RGBOG_IDX_ALL_GHI = 6'h2B;
  // byte address bits kept by the slave
  localparam int RGBOG_ADDR_W = 8;
  localparam int RGBOG_IDX_LSB = 2;
  // reset values
  localparam logic [7:0] RGBOG_OFS_RESET = 8'h80;
  localparam logic RGBOG_GLO_RESET = 1'b0;
  localparam logic [7:0] RGBOG_GHI_RESET = 8'h0C;
  // field positions, widths and channel numbering
  localparam int RGBOG_GLO_BIT = 0;
  localparam int RGBOG_GAIN_W = 9;
  localparam int RGBOG_CH_N = 3;
  typedef enum logic [1:0] {
    RGBOG_CH_RED = 2'h0,
    RGBOG_CH_GRN = 2'h1,
    RGBOG_CH_BLU = 2'h2
  } rgbog_ch_t;
endpackage : rgbog_pkg

//--- rgbog_decode.sv
// maps a register index to a channel selector and register kind
module rgbog_decode
  import rgbog_pkg::*;
(
  // index
  input wire logic [5:0] i_idx,
  // decoded
  output logic o_ofs,
  output logic o_glo,
  output logic o_ghi,
  output logic o_all,
  output logic o_hit,
  output logic [1:0] o_ch
);
  // index 0x20..0x2B: bits 3:2 kind, bits 1:0 channel or broadcast
  always_comb begin
    o_hit = (i_idx >= RGBOG_IDX_RED_OFS) && (i_idx <= RGBOG_IDX_ALL_GHI);
    o_ofs = o_hit && (i_idx[3:2] == 2'h0);
    o_glo = o_hit && (i_idx[3:2] == 2'h1);
    o_ghi = o_hit && (i_idx[3:2] == 2'h2);
    o_all = o_hit && (i_idx[1:0] == 2'h3);
    o_ch = i_idx[1:0];
  end
endmodule : rgbog_decode

//--- rgbog_regs.sv
// Operation
// - red offset code at 0x20, eight bits, resets to 0x80.
// - green offset code at 0x21, eight bits, resets to 0x80.
// - blue offset code at 0x22, eight bits, resets to 0x80.
// - writing 0x23 loads all three offset codes; nothing stored there.
// - bit 0 at 0x24 is red gain low bit, resets to zero.
// - bit 0 at 0x25 is green gain low bit, resets to zero.
// - bit 0 at 0x26 is blue gain low bit, resets to zero.
// - writing 0x27 loads bit 0 into all three gain low bits.
// - 0x28 holds red gain bits 8..1, resets to 0x0C.
// - 0x29 holds green gain bits 8..1, resets to 0x0C.
// - 0x2A holds blue gain bits 8..1, resets to 0x0C.
// - writing 0x2B loads all three gain high-bits registers.
// - full gain code is high bits above low bit, nine bits.
module rgbog_regs
  import rgbog_pkg::*;
#(
  parameter int ADDR_W = RGBOG_ADDR_W
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // channel codes to the analogue side
  output logic [7:0] o_red_offset_code,
  output logic [7:0] o_green_offset_code,
  output logic [7:0] o_blue_offset_code,
  output logic [8:0] o_red_gain_code,
  output logic [8:0] o_green_gain_code,
  output logic [8:0] o_blue_gain_code
);

  // elaboration check: index must fit in the address
  if (ADDR_W < 8) begin : g_bad_addr
    $error("address too narrow for register indices");
  end

  typedef struct packed {
    logic [RGBOG_CH_N-1:0][7:0] ofs;
    logic [RGBOG_CH_N-1:0] glo;
    logic [RGBOG_CH_N-1:0][7:0] ghi;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rgbog_state_t;

  rgbog_state_t st_reg;
  rgbog_state_t st_next;

  logic [5:0] idx;
  logic dec_ofs;
  logic dec_glo;
  logic dec_ghi;
  logic dec_all;
  logic dec_hit;
  logic [1:0] dec_ch;
  logic aligned;
  logic in_range;
  logic setup;
  logic wr_go;

  // word index from the byte address
  assign idx = i_paddr[RGBOG_IDX_LSB+5:RGBOG_IDX_LSB];
  assign aligned = (i_paddr[1:0] == 2'h0);
  assign in_range = (ADDR_W == 8) ? 1'b1
                  : (i_paddr >> (RGBOG_IDX_LSB + 6)) == '0;

  rgbog_decode u_decode (
    .i_idx(idx),
    .o_ofs(dec_ofs),
    .o_glo(dec_glo),
    .o_ghi(dec_ghi),
    .o_all(dec_all),
    .o_hit(dec_hit),
    .o_ch(dec_ch)
  );

  // zero-wait-state slave: setup registers read data and error, answer in access phase
  assign setup = i_psel && !i_penable;
  assign wr_go = i_psel && i_penable && st_reg.pready && i_pwrite
                 && aligned && in_range && dec_hit && i_pstrb[0];

  // read value for a single channel register
  function automatic logic [31:0] rd_word(input rgbog_state_t s,
                                          input logic ofs,
                                          input logic glo,
                                          input logic [1:0] ch);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (ofs) begin
      w[7:0] = s.ofs[ch];
    end else if (glo) begin
      w[RGBOG_GLO_BIT] = s.glo[ch];
    end else begin
      w[7:0] = s.ghi[ch];
    end
    return w;
  endfunction : rd_word

  // next state: bus answer and register writes
  always_comb begin
    st_next = st_reg;
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0; // error flag lives only with its ready pulse
    if (setup) begin
      st_next.pready = 1'b1;
      st_next.pslverr = !(aligned && in_range && dec_hit);
      st_next.prdata = 32'h0000_0000;
      if (!i_pwrite && aligned && in_range && dec_hit && !dec_all) begin
        st_next.prdata = rd_word(st_reg, dec_ofs, dec_glo, dec_ch);
      end
    end else if (i_psel && i_penable && st_reg.pready) begin
      st_next.pready = 1'b0;
    end
    if (wr_go) begin
      if (dec_ofs) begin
        if (dec_all) begin
          st_next.ofs = {RGBOG_CH_N{i_pwdata[7:0]}};
        end else begin
          st_next.ofs[dec_ch] = i_pwdata[7:0];
        end
      end else if (dec_glo) begin
        if (dec_all) begin
          st_next.glo = {RGBOG_CH_N{i_pwdata[RGBOG_GLO_BIT]}};
        end else begin
          st_next.glo[dec_ch] = i_pwdata[RGBOG_GLO_BIT];
        end
      end else begin
        if (dec_all) begin
          st_next.ghi = {RGBOG_CH_N{i_pwdata[7:0]}};
        end else begin
          st_next.ghi[dec_ch] = i_pwdata[7:0];
        end
      end
    end
  end

  // state register with synchronous reset
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_reg.ofs <= {RGBOG_CH_N{RGBOG_OFS_RESET}};
      st_reg.glo <= {RGBOG_CH_N{RGBOG_GLO_RESET}};
      st_reg.ghi <= {RGBOG_CH_N{RGBOG_GHI_RESET}};
      st_reg.prdata <= 32'h0000_0000;
      st_reg.pready <= 1'b0;
      st_reg.pslverr <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flops
  assign o_prdata = st_reg.prdata;
  assign o_pready = st_reg.pready;
  assign o_pslverr = st_reg.pslverr;
  assign o_red_offset_code = st_reg.ofs[RGBOG_CH_RED];
  assign o_green_offset_code = st_reg.ofs[RGBOG_CH_GRN];
  assign o_blue_offset_code = st_reg.ofs[RGBOG_CH_BLU];
  // full gain code: high bits above the low bit
  assign o_red_gain_code = {st_reg.ghi[RGBOG_CH_RED],
                            st_reg.glo[RGBOG_CH_RED]};
  assign o_green_gain_code = {st_reg.ghi[RGBOG_CH_GRN],
                              st_reg.glo[RGBOG_CH_GRN]};
  assign o_blue_gain_code = {st_reg.ghi[RGBOG_CH_BLU],
                             st_reg.glo[RGBOG_CH_BLU]};

endmodule : rgbog_regs

//--- rgbog_asserts.sv
module rgbog_asserts
  import rgbog_pkg::*;
#(parameter int ADDR_W = RGBOG_ADDR_W) (
  // apb side
  input wire logic i_clk, i_reset, i_psel, i_penable, i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata, o_prdata,
  input wire logic [3:0] i_pstrb,
  input wire logic o_pready, o_pslverr,
  // channel codes
  input wire logic [7:0] o_red_offset_code, o_green_offset_code,
  input wire logic [7:0] o_blue_offset_code,
  input wire logic [8:0] o_red_gain_code, o_green_gain_code,
  input wire logic [8:0] o_blue_gain_code
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic [5:0] ix;
  logic [7:0] d;
  // register index and write byte
  assign ix = i_paddr[7:2];
  assign d = i_pwdata[7:0];
  // accepted write to one index
  sequence wr_s(logic [5:0] a);
    i_psel && i_penable && i_pwrite && o_pready && i_pstrb[0] &&
      !o_pslverr && ix == a;
  endsequence
  ofs_bcast_a: assert property (wr_s(6'h23) |=>
    {o_red_offset_code, o_green_offset_code, o_blue_offset_code} ==
      {3{$past(d)}}) else $error("offset broadcast wrong");
  red_ofs_a: assert property (wr_s(6'h20) |=>
    o_red_offset_code == $past(d) && $stable(o_green_offset_code))
    else $error("red offset write wrong");
  blu_ofs_a: assert property (wr_s(6'h22) |=>
    o_blue_offset_code == $past(d)) else $error("blue offset wrong");
  glo_bcast_a: assert property (wr_s(6'h27) |=>
    {o_red_gain_code[0], o_green_gain_code[0], o_blue_gain_code[0]}
      == {3{$past(d[0])}}) else $error("low bit broadcast wrong");
  ghi_bcast_a: assert property (wr_s(6'h2B) |=>
    {o_red_gain_code[8:1], o_green_gain_code[8:1],
      o_blue_gain_code[8:1]} == {3{$past(d)}})
    else $error("high bits broadcast wrong");
  grn_glo_a: assert property (wr_s(6'h25) |=>
    o_green_gain_code[0] == $past(d[0])) else $error("green low wrong");
  blu_ghi_a: assert property (wr_s(6'h2A) |=>
    o_blue_gain_code[8:1] == $past(d)) else $error("blue high wrong");
  idle_hold_a: assert property (!(i_psel && i_penable) |=>
    $stable({o_red_offset_code, o_red_gain_code, o_blue_gain_code}))
    else $error("codes moved without write");
endmodule : rgbog_asserts

bind rgbog_regs rgbog_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);

//--- tb_rgb_offset_gain_registers.sv
module tb_rgb_offset_gain_registers;
  timeunit 1ns;
  timeprecision 1ns;
  import rgbog_pkg::*;
  logic clk = 1'h0, rst = 1'h1, sel = 1'h0, en = 1'h0, wr = 1'h0;
  logic [7:0] adr = 8'h00, ro, go, bo;
  logic [31:0] wd = 32'h0, rd, q;
  logic rdy, err, e;
  logic [8:0] rg, gg, bg;
  int err_total = 0, n_compared = 0;
  rgbog_regs DUT (.i_clk(clk), .i_reset(rst), .i_psel(sel),
    .i_penable(en), .i_pwrite(wr), .i_paddr(adr), .i_pwdata(wd),
    .i_pstrb(4'hF), .o_prdata(rd), .o_pready(rdy), .o_pslverr(err),
    .o_red_offset_code(ro), .o_green_offset_code(go),
    .o_blue_offset_code(bo), .o_red_gain_code(rg),
    .o_green_gain_code(gg), .o_blue_gain_code(bg));
  // clock, 40 ns
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic end_sim;
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic chk(input string s, input logic [31:0] x, y);
    n_compared++;
    if (y !== x) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", s, x, y);
    end
  endtask : chk
  // one apb transfer, then one idle cycle
  task automatic apb(input logic w, input logic [5:0] ix,
      input logic [7:0] dv);
    sel <= 1'h1;
    wr <= w;
    adr <= {ix, 2'h0};
    wd <= {24'h0, dv};
    @(posedge clk) en <= 1'h1;
    @(posedge clk);
    while (rdy !== 1'h1) @(posedge clk);
    q = rd;
    e = err;
    sel <= 1'h0;
    en <= 1'h0;
    @(posedge clk);
  endtask : apb
  task automatic t_reset;
    for (int i = 0; i < 12; i++) begin
      apb(1'h0, 6'h20 + 6'(i), 8'h00);
      chk("reset rd", i < 3 ? 8'h80 : (i > 7 && i < 11) ? 8'h0C : 8'h00,
        q);
    end
    chk("ofs", 24'h808080, {ro, go, bo});
    chk("gain", {3{9'h018}}, {rg, gg, bg});
  endtask : t_reset
  task automatic t_chan;
    for (int i = 0; i < 9; i++) begin
      apb(1'h1, 6'h20 + 6'(i + i / 3),
        (i / 3 == 1) ? 8'(i == 4) : 8'h11 * 8'(i + 1));
    end
    apb(1'h0, 6'h25, 8'h00);
    chk("low rd", 32'h1, q);
    chk("err ok", 1'h0, e);
    chk("ofs", 24'h112233, {ro, go, bo});
    chk("gain", {8'h77, 1'h0, 8'h88, 1'h1, 8'h99, 1'h0},
      {rg, gg, bg});
  endtask : t_chan
  task automatic t_bcast;
    apb(1'h1, 6'h23, 8'h5A);
    apb(1'h1, 6'h27, 8'h01);
    apb(1'h1, 6'h2B, 8'hA5);
    chk("ofs", 24'h5A5A5A, {ro, go, bo});
    chk("gain", {3{9'h14B}}, {rg, gg, bg});
    apb(1'h1, 6'h27, 8'h00);
    chk("gain", {3{9'h14A}}, {rg, gg, bg});
    apb(1'h0, 6'h23, 8'h00);
    chk("bc rd", 32'h0, q);
  endtask : t_bcast
  task automatic t_bad;
    apb(1'h1, 6'h30, 8'h77);
    chk("err", 1'h1, e);
    chk("ofs", 24'h5A5A5A, {ro, go, bo});
  endtask : t_bad
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_chan();
    t_bcast();
    t_bad();
    end_sim();
  end
  // watchdog
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    end_sim();
  end
endmodule : tb_rgb_offset_gain_registers
